// >>> rxcr_top.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

// What this block does
// - Non-bonded: parallel recovered clock divided from serial; deserializer on serial clock.
// - Non-bonded: aligner and rate-match write on own parallel recovered clock.
// - Non-bonded: rate-match read, decoder, byte deserializer on local transmit divider.
// - Non-bonded: phase FIFO on transmit clock, halved with byte deserializer, forwarded.
// - Single-lane PCIe: 250 or 500 MHz datapath; 5 Gbps needs byte deserializer.
// - GigE 125 MHz datapath; RapidIO 3.125G 312.5 MHz with 156.25 MHz fabric clock.
// - Four lanes bond in one block; eight lanes span two blocks.
// - Bonded lanes share one divider: first clock multiplier or auxiliary PLL.
// - Bonded phase FIFOs share central pointers for equal latency.
// - Generic four/eight-lane modes never bond but reuse PCIe clocking.
// - Four-lane deskew: each aligner on its own recovered clock.
// - Four-lane deskew: deskew and rate-match write on lane 0 recovered clock.
// - Four-lane: rate-match read, decoder, byte deserializer on shared divider.
// - Four-lane without deskew: aligner and rate-match write on own lane clock.
// - Four-lane PCIe: 250 or 500 MHz; 5 Gbps needs byte deserializer.
// - Eight-lane PCIe: master block lanes 0-3, slave block lanes 4-7.
// - Eight-lane: read side clocks from master divider, forwarded as core clock.
module rxcr_top (
	input wire logic ref_clk, // system clock, 200 MHz
	input wire logic srst, // sync reset, active high
	input wire logic ce, // clock enable, freezes all state
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after strobe
	input wire logic [rxcr_pkg::LANES-1:0] cdr_lock_pin, // per-lane CDR lock, asynchronous
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] deser_src, // deserializer clock source
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] prc_src, // parallel recovered clock origin
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] wa_src, // word aligner clock source
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] rmw_src, // rate-match write clock source
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] dsk_src, // deskew FIFO clock source
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] rmr_src, // rate-match read clock source
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] dec_src, // 8B/10B decoder clock source
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] bdw_src, // byte deserializer write source
	output logic [rxcr_pkg::LANES*rxcr_pkg::SRC_W-1:0] pcf_src, // phase FIFO write source
	output logic [rxcr_pkg::LANES-1:0] slave_block, // lane sits in slave block
	output logic shared_div_aux, // shared divider is auxiliary PLL
	output logic fwd_core, // forwarded clock is core clock of four/eight-lane modes
	output logic fwd_half, // forwarded clock halved
	output logic ptr_shared, // phase FIFO pointers central
	output logic bonded, // receive lanes bonded
	output logic cfg_ok, // applied configuration running
	output logic fwd_tick // forwarded interface clock strobe
);
	// ------------------------------------------------------------
	// Registers and synchroniser
	// ------------------------------------------------------------
	logic [rxcr_pkg::CTRL_W-1:0] ctrl_r;
	logic [7:0] ratio_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [rxcr_pkg::LANES-1:0] lock_meta_r;
	logic [rxcr_pkg::LANES-1:0] lock_r;
	logic err_r;
	rxcr_pkg::rxcr_state_t state_r;
	rxcr_pkg::rxcr_state_t state_nxt;

	wire wr_ctrl = reg_wr && (reg_addr == rxcr_pkg::REG_CTRL);
	wire wr_ratio = reg_wr && (reg_addr == rxcr_pkg::REG_RATIO);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_r <= rxcr_pkg::CTRL_RST;
			ratio_r <= rxcr_pkg::RATIO_RST;
			lock_meta_r <= '0;
			lock_r <= '0;
		end else if (ce) begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata[rxcr_pkg::CTRL_W-1:0];
			if (wr_ratio)
				ratio_r <= reg_wdata[7:0];
			lock_meta_r <= cdr_lock_pin;
			lock_r <= lock_meta_r;
		end
	end

	// ------------------------------------------------------------
	// Configuration decode
	// ------------------------------------------------------------
	wire [2:0] mode_f = ctrl_r[rxcr_pkg::CTRL_MODE_LSB +: 3];
	wire [2:0] proto_f = ctrl_r[rxcr_pkg::CTRL_PROTO_LSB +: 3];
	wire bdes = ctrl_r[rxcr_pkg::CTRL_BDES_BIT];
	wire rate_hi = ctrl_r[rxcr_pkg::CTRL_RATE_BIT];
	wire dsrc_aux = ctrl_r[rxcr_pkg::CTRL_DSRC_BIT];
	wire enable = ctrl_r[rxcr_pkg::CTRL_EN_BIT];

	wire m_nb = (mode_f == rxcr_pkg::RXCR_MODE_NB_RM);
	wire m_x4d = (mode_f == rxcr_pkg::RXCR_MODE_X4_DESKEW);
	wire m_x4n = (mode_f == rxcr_pkg::RXCR_MODE_X4_NODESKEW);
	wire m_x8 = (mode_f == rxcr_pkg::RXCR_MODE_X8);
	wire m_bx4 = (mode_f == rxcr_pkg::RXCR_MODE_BASIC_X4);
	wire m_bx8 = (mode_f == rxcr_pkg::RXCR_MODE_BASIC_X8);
	wire four_lane = m_x4d || m_x4n || m_bx4;
	wire eight_lane = m_x8 || m_bx8;

	wire p_pcie = (proto_f == rxcr_pkg::RXCR_PROTO_PCIE);
	wire p_gige = (proto_f == rxcr_pkg::RXCR_PROTO_GIGE);
	wire p_srio = (proto_f == rxcr_pkg::RXCR_PROTO_SRIO);
	wire p_xaui = (proto_f == rxcr_pkg::RXCR_PROTO_XAUI);
	wire p_basic = (proto_f == rxcr_pkg::RXCR_PROTO_BASIC);

	// Only the listed protocol/mode pairings are legal
	wire ok_pcie = p_pcie && (m_nb || m_x4n || m_x8) && (!rate_hi || bdes);
	wire ok_gige = p_gige && m_nb && !rate_hi;
	wire ok_srio = p_srio && m_nb && bdes;
	wire ok_xaui = p_xaui && m_x4d && rate_hi && bdes;
	wire ok_basic = p_basic && (m_nb || m_bx4 || m_bx8);
	wire legal = ok_pcie || ok_gige || ok_srio || ok_xaui || ok_basic;

	// Datapath clock follows line rate; fabric clock halves with byte deserializer
	wire [rxcr_pkg::FREQ_W-1:0] dp_pcie = rate_hi ? rxcr_pkg::F_500M : rxcr_pkg::F_250M;
	wire [rxcr_pkg::FREQ_W-1:0] dp_srio = rate_hi ? rxcr_pkg::F_312M5 : rxcr_pkg::F_250M;
	wire [rxcr_pkg::FREQ_W-1:0] dp_freq =
		p_pcie ? dp_pcie :
		p_gige ? rxcr_pkg::F_125M :
		p_srio ? dp_srio :
		p_xaui ? rxcr_pkg::F_312M5 : rxcr_pkg::F_NONE;
	wire [rxcr_pkg::FREQ_W-1:0] fab_freq = bdes ? (dp_freq >> 1) : dp_freq;

	// ------------------------------------------------------------
	// Apply sequence
	// ------------------------------------------------------------
	// Sources take control word values only in apply, so a half-written control word never reaches the clocks
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			rxcr_pkg::RXCR_ST_IDLE: begin
				if (enable)
					state_nxt = rxcr_pkg::RXCR_ST_CHECK;
			end
			rxcr_pkg::RXCR_ST_CHECK: begin
				state_nxt = legal ? rxcr_pkg::RXCR_ST_APPLY : rxcr_pkg::RXCR_ST_IDLE;
			end
			rxcr_pkg::RXCR_ST_APPLY: begin
				state_nxt = rxcr_pkg::RXCR_ST_RUN;
			end
			rxcr_pkg::RXCR_ST_RUN: begin
				if (wr_ctrl)
					state_nxt = rxcr_pkg::RXCR_ST_IDLE;
			end
			default: begin
				state_nxt = rxcr_pkg::RXCR_ST_IDLE;
			end
		endcase
		if (!enable)
			state_nxt = rxcr_pkg::RXCR_ST_IDLE;
	end

	wire do_apply = (state_r == rxcr_pkg::RXCR_ST_APPLY);
	wire do_clear = (state_r == rxcr_pkg::RXCR_ST_IDLE);
	wire running = (state_r == rxcr_pkg::RXCR_ST_RUN);

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r <= rxcr_pkg::RXCR_ST_IDLE;
			err_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			if (state_r == rxcr_pkg::RXCR_ST_CHECK)
				err_r <= !legal;
			else if (wr_ctrl)
				err_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Per-lane clock routing
	// ------------------------------------------------------------
	// Read-side source: own transmit divider, shared block divider, or master block divider
	wire [rxcr_pkg::SRC_W-1:0] rd_side =
		m_nb ? rxcr_pkg::RXCR_SRC_LOCAL_DIV :
		eight_lane ? rxcr_pkg::RXCR_SRC_MASTER_DIV :
		rxcr_pkg::RXCR_SRC_SHARED_DIV;

	genvar gl;
	generate
		for (gl = 0; gl < rxcr_pkg::LANES; gl++) begin : g_lane
			localparam int LO = gl * rxcr_pkg::SRC_W;
			// Upper four lanes sit out the four-lane modes and run in non-bonded and eight-lane modes
			wire active = m_nb || eight_lane || (four_lane && gl < rxcr_pkg::LANES_PER_BLOCK);
			wire [rxcr_pkg::SRC_W-1:0] off = rxcr_pkg::RXCR_SRC_OFF;
			wire [rxcr_pkg::SRC_W-1:0] own = rxcr_pkg::RXCR_SRC_OWN_PRC;
			wire [rxcr_pkg::SRC_W-1:0] ser_n = active ? rxcr_pkg::RXCR_SRC_SERIAL : off;
			wire [rxcr_pkg::SRC_W-1:0] wa_n = active ? own : off;
			wire [rxcr_pkg::SRC_W-1:0] rmw_n = !active ? off :
				m_x4d ? rxcr_pkg::RXCR_SRC_LANE0_PRC : own;
			wire [rxcr_pkg::SRC_W-1:0] dsk_n = (active && m_x4d) ? rxcr_pkg::RXCR_SRC_LANE0_PRC : off;
			wire [rxcr_pkg::SRC_W-1:0] rd_n = active ? rd_side : off;
			wire [rxcr_pkg::SRC_W-1:0] bdw_n = bdes ? rd_n : off;
			logic [rxcr_pkg::SRC_W-1:0] ser_r;
			logic [rxcr_pkg::SRC_W-1:0] wa_r;
			logic [rxcr_pkg::SRC_W-1:0] rmw_r;
			logic [rxcr_pkg::SRC_W-1:0] dsk_r;
			logic [rxcr_pkg::SRC_W-1:0] rd_r;
			logic [rxcr_pkg::SRC_W-1:0] bdw_r;
			logic slv_r;

			always_ff @(posedge ref_clk) begin
				if (srst || (ce && do_clear)) begin
					ser_r <= off;
					wa_r <= off;
					rmw_r <= off;
					dsk_r <= off;
					rd_r <= off;
					bdw_r <= off;
					slv_r <= 1'b0;
				end else if (ce && do_apply) begin
					ser_r <= ser_n;
					wa_r <= wa_n;
					rmw_r <= rmw_n;
					dsk_r <= dsk_n;
					rd_r <= rd_n;
					bdw_r <= bdw_n;
					slv_r <= eight_lane && gl >= rxcr_pkg::LANES_PER_BLOCK;
				end
			end

			assign deser_src[LO +: rxcr_pkg::SRC_W] = ser_r;
			assign prc_src[LO +: rxcr_pkg::SRC_W] = ser_r;
			assign wa_src[LO +: rxcr_pkg::SRC_W] = wa_r;
			assign rmw_src[LO +: rxcr_pkg::SRC_W] = rmw_r;
			assign dsk_src[LO +: rxcr_pkg::SRC_W] = dsk_r;
			assign rmr_src[LO +: rxcr_pkg::SRC_W] = rd_r;
			assign dec_src[LO +: rxcr_pkg::SRC_W] = rd_r;
			assign bdw_src[LO +: rxcr_pkg::SRC_W] = bdw_r;
			assign pcf_src[LO +: rxcr_pkg::SRC_W] = rd_r;
			assign slave_block[gl] = slv_r;
		end
	endgenerate

	// ------------------------------------------------------------
	// Bonding flags and forwarded clock
	// ------------------------------------------------------------
	logic bonded_r;
	logic core_r;
	logic half_r;
	logic aux_r;

	always_ff @(posedge ref_clk) begin
		if (srst || (ce && do_clear)) begin
			bonded_r <= 1'b0;
			core_r <= 1'b0;
			half_r <= 1'b0;
			aux_r <= 1'b0;
		end else if (ce && do_apply) begin
			bonded_r <= m_x4d || m_x4n || m_x8;
			core_r <= !m_nb;
			half_r <= bdes;
			aux_r <= !m_nb && dsrc_aux;
		end
	end

	assign bonded = bonded_r;
	assign ptr_shared = bonded_r;
	assign fwd_core = core_r;
	assign fwd_half = half_r;
	assign shared_div_aux = aux_r;
	assign cfg_ok = running;

	// One divider makes the forwarded strobe fwd_tick for all lanes, so the fabric sees a single clock
	rxcr_div u_fwd_div (
		.ref_clk(ref_clk),
		.srst(srst),
		.ce(ce),
		.run(running),
		.ratio(ratio_r),
		.halve(half_r),
		.tick(fwd_tick)
	);

	// ------------------------------------------------------------
	// Register read
	// ------------------------------------------------------------
	wire [31:0] status_w = {16'h0000, lock_r, state_r, err_r, half_r, core_r, bonded_r, bonded_r, running};
	wire [31:0] ctrl_w = {{(32 - rxcr_pkg::CTRL_W){1'b0}}, ctrl_r};

	always_comb begin
		rdata_nxt = 32'h00000000;
		case (reg_addr)
			rxcr_pkg::REG_CTRL: rdata_nxt = ctrl_w;
			rxcr_pkg::REG_STATUS: rdata_nxt = status_w;
			rxcr_pkg::REG_DP_FREQ: rdata_nxt = {12'h000, dp_freq};
			rxcr_pkg::REG_FAB_FREQ: rdata_nxt = {12'h000, fab_freq};
			rxcr_pkg::REG_RATIO: rdata_nxt = {24'h000000, ratio_r};
			default: rdata_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			rdata_r <= 32'h00000000;
		else if (ce)
			rdata_r <= reg_rd ? rdata_nxt : 32'h00000000;
	end

	assign reg_rdata = rdata_r;
endmodule

// >>> rxcr_div.sv
package rxcr_pkg;
	localparam int LANES = 8;
	localparam int SRC_W = 3;
	localparam int FREQ_W = 20;
	localparam int LANES_PER_BLOCK = 4;
	localparam int LANE0 = 0;

	typedef enum logic [2:0] {
		RXCR_SRC_OFF = 3'h0,
		RXCR_SRC_SERIAL = 3'h1,
		RXCR_SRC_OWN_PRC = 3'h2,
		RXCR_SRC_LANE0_PRC = 3'h3,
		RXCR_SRC_LOCAL_DIV = 3'h4,
		RXCR_SRC_SHARED_DIV = 3'h5,
		RXCR_SRC_MASTER_DIV = 3'h6
	} rxcr_src_t;

	typedef enum logic [2:0] {
		RXCR_MODE_NB_RM = 3'h0,
		RXCR_MODE_X4_DESKEW = 3'h1,
		RXCR_MODE_X4_NODESKEW = 3'h2,
		RXCR_MODE_X8 = 3'h3,
		RXCR_MODE_BASIC_X4 = 3'h4,
		RXCR_MODE_BASIC_X8 = 3'h5
	} rxcr_mode_t;

	typedef enum logic [2:0] {
		RXCR_PROTO_PCIE = 3'h0,
		RXCR_PROTO_GIGE = 3'h1,
		RXCR_PROTO_SRIO = 3'h2,
		RXCR_PROTO_XAUI = 3'h3,
		RXCR_PROTO_BASIC = 3'h4
	} rxcr_proto_t;

	// Gray order along idle, check, apply, run
	typedef enum logic [1:0] {
		RXCR_ST_IDLE = 2'h0,
		RXCR_ST_CHECK = 2'h1,
		RXCR_ST_APPLY = 2'h3,
		RXCR_ST_RUN = 2'h2
	} rxcr_state_t;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DP_FREQ = 8'h08;
	localparam logic [7:0] REG_FAB_FREQ = 8'h0C;
	localparam logic [7:0] REG_RATIO = 8'h10;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_BDES_BIT = 3;
	localparam int CTRL_RATE_BIT = 4;
	localparam int CTRL_DSRC_BIT = 5;
	localparam int CTRL_EN_BIT = 6;
	localparam int CTRL_PROTO_LSB = 8;
	localparam int CTRL_W = 11;
	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
	localparam logic [7:0] RATIO_RST = 8'h04;

	localparam int STAT_OK_BIT = 0;
	localparam int STAT_BOND_BIT = 1;
	localparam int STAT_PTR_BIT = 2;
	localparam int STAT_CORE_BIT = 3;
	localparam int STAT_HALF_BIT = 4;
	localparam int STAT_ERR_BIT = 5;
	localparam int STAT_STATE_LSB = 6;
	localparam int STAT_LOCK_LSB = 8;

	// Frequencies in kHz
	localparam logic [FREQ_W-1:0] F_NONE = 20'h00000;
	localparam logic [FREQ_W-1:0] F_62M5 = 20'h0F424;
	localparam logic [FREQ_W-1:0] F_125M = 20'h1E848;
	localparam logic [FREQ_W-1:0] F_156M25 = 20'h2625A;
	localparam logic [FREQ_W-1:0] F_250M = 20'h3D090;
	localparam logic [FREQ_W-1:0] F_312M5 = 20'h4C4B4;
	localparam logic [FREQ_W-1:0] F_500M = 20'h7A120;
endpackage

`timescale 1ns/1ps

module rxcr_div (
	input wire logic ref_clk, // system clock
	input wire logic srst, // sync reset, active high
	input wire logic ce, // clock enable
	input wire logic run, // divider runs
	input wire logic [7:0] ratio, // divide ratio, 0 treated as 1
	input wire logic halve, // extra divide by two
	output logic tick // one-cycle strobe of divided clock
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic half_r;
	logic tick_r;
	logic wrap;

	assign wrap = (cnt_r + 8'h01 >= ratio);
	assign cnt_nxt = wrap ? 8'h00 : cnt_r + 8'h01;
	assign tick = tick_r;

	always_ff @(posedge ref_clk) begin
		if (srst || !run) begin
			cnt_r <= 8'h00;
			half_r <= 1'b0;
			tick_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			if (wrap)
				half_r <= ~half_r;
			tick_r <= wrap && (!halve || half_r);
		end
	end
endmodule

// >>> rxcr_top_asserts.sv
`timescale 1ns/1ps

module rxcr_chk (
	input wire logic ref_clk, // clock
	input wire logic srst, // reset
	input wire logic ce, // enable
	input wire logic [7:0] reg_addr, // address
	input wire logic reg_wr, // write
	input wire logic cfg_ok, // running
	input wire logic fwd_tick, // fwd clock
	input wire logic fwd_core, // core clock
	input wire logic bonded, // bonded
	input wire logic ptr_shared, // pointers
	input wire logic [23:0] deser_src, // deser
	input wire logic [23:0] prc_src, // prc
	input wire logic [23:0] wa_src, // aligner
	input wire logic [23:0] rmw_src, // rm write
	input wire logic [23:0] dsk_src, // deskew
	input wire logic [23:0] rmr_src, // rm read
	input wire logic [23:0] pcf_src, // phase fifo
	input wire logic [7:0] slave_block // slave
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence s_ctrl_wr;
		ce && reg_wr && reg_addr == rxcr_pkg::REG_CTRL;
	endsequence
	sequence s_nb_run;
		cfg_ok && !fwd_core;
	endsequence
	a_ptr_bond: assert property (ptr_shared == bonded && (!ptr_shared || (pcf_src[11:9] == pcf_src[2:0] &&
		pcf_src[2:0] != rxcr_pkg::RXCR_SRC_LOCAL_DIV))) else $error("pointer sharing differs");
	a_bond_core: assert property (bonded |-> fwd_core) else $error("bonded without core clock");
	a_tick_run: assert property (fwd_tick |-> $past(cfg_ok)) else $error("tick outside run");
	a_nb_serial: assert property (s_nb_run |-> deser_src[2:0] == rxcr_pkg::RXCR_SRC_SERIAL &&
		prc_src[2:0] == rxcr_pkg::RXCR_SRC_SERIAL) else $error("deserializer not on serial clock");
	a_nb_own: assert property (s_nb_run |-> wa_src[2:0] == rxcr_pkg::RXCR_SRC_OWN_PRC &&
		rmw_src[2:0] == rxcr_pkg::RXCR_SRC_OWN_PRC) else $error("aligner not on own clock");
	a_nb_local: assert property (s_nb_run |-> rmr_src[2:0] == rxcr_pkg::RXCR_SRC_LOCAL_DIV &&
		pcf_src[2:0] == rxcr_pkg::RXCR_SRC_LOCAL_DIV) else $error("read side not on local divider");
	a_dsk_lane0: assert property (cfg_ok && dsk_src[5:3] == rxcr_pkg::RXCR_SRC_LANE0_PRC |->
		rmw_src[5:3] == rxcr_pkg::RXCR_SRC_LANE0_PRC && wa_src[5:3] == rxcr_pkg::RXCR_SRC_OWN_PRC)
		else $error("deskew lane clocks wrong");
	a_x8_master: assert property (cfg_ok && slave_block[4] |->
		rmr_src[14:12] == rxcr_pkg::RXCR_SRC_MASTER_DIV && pcf_src[2:0] == rxcr_pkg::RXCR_SRC_MASTER_DIV)
		else $error("eight-lane read side not on master divider");
	a_wr_stops: assert property ((cfg_ok ##0 s_ctrl_wr) ##1 ce |-> !cfg_ok ##1 (pcf_src == '0 && !bonded))
		else $error("control write did not stop routing");
endmodule

bind rxcr_top rxcr_chk u_chk (.ref_clk, .srst, .ce, .reg_addr, .reg_wr, .cfg_ok, .fwd_tick, .fwd_core,
	.bonded, .ptr_shared, .deser_src, .prc_src, .wa_src, .rmw_src, .dsk_src, .rmr_src, .pcf_src, .slave_block);

// >>> rxcr_fabric.sv
`timescale 1ns/1ps

module rxcr_fabric (
	input wire logic ref_clk, // clock
	input wire logic srst, // reset
	input wire logic fwd_tick, // forwarded clock edge
	output logic [15:0] gap // cycles between captures
);
	logic [15:0] cnt_r;
	// Captures only on the forwarded clock, never on a free clock
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_r <= '0;
			gap <= '0;
		end else if (fwd_tick) begin
			gap <= cnt_r + 16'h0001;
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps

module testbench;
	localparam logic [2:0] S_OFF = rxcr_pkg::RXCR_SRC_OFF;
	localparam logic [2:0] S_OWN = rxcr_pkg::RXCR_SRC_OWN_PRC;
	logic ref_clk = 0, srst = 1, ce = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = '0, cdr_lock_pin = '0, slave_block;
	logic [31:0] reg_wdata = '0, reg_rdata;
	logic [23:0] deser_src, prc_src, wa_src, rmw_src, dsk_src, rmr_src, dec_src, bdw_src, pcf_src;
	logic shared_div_aux, fwd_core, fwd_half, ptr_shared, bonded, cfg_ok, fwd_tick;
	logic [15:0] gap;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	logic [10:0] cfg [9] = '{11'h040, 11'h058, 11'h148, 11'h258, 11'h359, 11'h062, 11'h05B, 11'h444, 11'h445};
	logic [19:0] dpf [9] = '{rxcr_pkg::F_250M, rxcr_pkg::F_500M, rxcr_pkg::F_125M, rxcr_pkg::F_312M5,
		rxcr_pkg::F_312M5, rxcr_pkg::F_250M, rxcr_pkg::F_500M, rxcr_pkg::F_NONE, rxcr_pkg::F_NONE};
	logic [10:0] bad [3] = '{11'h050, 11'h340, 11'h072};

	always #2.5 ref_clk = ~ref_clk;

	rxcr_top uut (.ref_clk, .srst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cdr_lock_pin,
		.deser_src, .prc_src, .wa_src, .rmw_src, .dsk_src, .rmr_src, .dec_src, .bdw_src, .pcf_src,
		.slave_block, .shared_div_aux, .fwd_core, .fwd_half, .ptr_shared, .bonded, .cfg_ok, .fwd_tick);
	rxcr_fabric fab (.ref_clk, .srst, .fwd_tick, .gap);

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] e);
		n_checks++;
		if (seen !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard, far above the roughly 600 cycles needed
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		int r;
		logic [2:0] m, rs;
		logic nb, x8, act, bd, bo;
		r = $urandom(91511);
		repeat (20) @(posedge ref_clk);
		srst <= 0;
		rd(rxcr_pkg::REG_RATIO, d);
		check(d, 32'h00000004);
		rd(8'h14, d);
		check(d, 32'h00000000);
		for (int i = 0; i < 9; i++) begin
			cdr_lock_pin <= 8'($urandom);
			wr(rxcr_pkg::REG_CTRL, 32'h0);
			repeat (3) @(posedge ref_clk);
			wr(rxcr_pkg::REG_CTRL, {21'h0, cfg[i]});
			repeat (2) @(posedge ref_clk);
			#1 check(cfg_ok, 1'b0);
			@(posedge ref_clk);
			#1 check(cfg_ok, 1'b1);
			m = cfg[i][2:0];
			nb = m == 3'h0;
			x8 = m == 3'h3 || m == 3'h5;
			bd = cfg[i][3];
			bo = m >= 3'h1 && m <= 3'h3;
			check(bonded, bo);
			check(fwd_core, !nb);
			check(fwd_half, bd);
			check(shared_div_aux, !nb && cfg[i][5]);
			check(slave_block, x8 ? 8'hF0 : 8'h00);
			for (int l = 0; l < 8; l += 5) begin
				act = !(l >= 4 && (m == 3'h1 || m == 3'h2 || m == 3'h4));
				rs = !act ? S_OFF : nb ? rxcr_pkg::RXCR_SRC_LOCAL_DIV :
					x8 ? rxcr_pkg::RXCR_SRC_MASTER_DIV : rxcr_pkg::RXCR_SRC_SHARED_DIV;
				check(deser_src[3*l+:3], act ? rxcr_pkg::RXCR_SRC_SERIAL : S_OFF);
				check(wa_src[3*l+:3], act ? S_OWN : S_OFF);
				check(rmw_src[3*l+:3], !act ? S_OFF : m == 3'h1 ? rxcr_pkg::RXCR_SRC_LANE0_PRC : S_OWN);
				check(dsk_src[3*l+:3], act && m == 3'h1 ? rxcr_pkg::RXCR_SRC_LANE0_PRC : S_OFF);
				check(prc_src[3*l+:3], act ? rxcr_pkg::RXCR_SRC_SERIAL : S_OFF);
				check(rmr_src[3*l+:3], rs);
				check(dec_src[3*l+:3], rs);
				check(bdw_src[3*l+:3], bd ? rs : S_OFF);
				check(pcf_src[3*l+:3], rs);
			end
			rd(rxcr_pkg::REG_DP_FREQ, d);
			check(d, dpf[i]);
			rd(rxcr_pkg::REG_FAB_FREQ, d);
			check(d, bd ? dpf[i] >> 1 : dpf[i]);
			rd(rxcr_pkg::REG_STATUS, d);
			check(d[15:0], {cdr_lock_pin, 2'b10, 1'b0, bd, !nb, bo, bo, 1'b1});
			r = i ? $urandom_range(1, 8) : 0;
			wr(rxcr_pkg::REG_RATIO, r);
			repeat (40) @(posedge ref_clk);
			#1 check(gap, (r ? r : 1) * (bd ? 2 : 1));
			$display("config %0d done", i);
		end
		foreach (bad[i]) begin
			wr(rxcr_pkg::REG_CTRL, 32'h0);
			repeat (3) @(posedge ref_clk);
			wr(rxcr_pkg::REG_CTRL, {21'h0, bad[i]});
			repeat (3) @(posedge ref_clk);
			#1 check(cfg_ok, 1'b0);
			check(pcf_src, 24'h0);
			rd(rxcr_pkg::REG_STATUS, d);
			check(d[7:5], 3'b001);
			$display("refused config %0d done", i);
		end
		// Enable low must freeze the running setup against a control write; a mid-run reset clears the setup and the strobe and reloads ratio 4
		wr(rxcr_pkg::REG_CTRL, {21'h0, cfg[3]});
		repeat (4) @(posedge ref_clk);
		ce <= 0;
		wr(rxcr_pkg::REG_CTRL, 32'h0);
		repeat (4) @(posedge ref_clk);
		#1 check(cfg_ok, 1'b1);
		check(pcf_src[2:0], rxcr_pkg::RXCR_SRC_LOCAL_DIV);
		@(posedge ref_clk);
		ce <= 1;
		repeat (2) @(posedge ref_clk);
		#1 check(cfg_ok, 1'b1);
		@(posedge ref_clk);
		srst <= 1;
		@(posedge ref_clk);
		srst <= 0;
		#1 check(cfg_ok, 1'b0);
		check(pcf_src, 24'h0);
		check(fwd_tick, 1'b0);
		rd(rxcr_pkg::REG_RATIO, d);
		check(d, 32'h00000004);
		rd(rxcr_pkg::REG_CTRL, d);
		check(d, 32'h00000000);
		$display("enable and reset test done");
		results();
	end
endmodule
